// *** common/chanmem_pkg.sv ***
`default_nettype none
package chanmem_pkg;
   // slot 0 is the scratchpad, slots 1..100 are numbered channels
   localparam int unsigned NUM_CHAN = 100;
   localparam int unsigned CHAN_W = 7;
   localparam logic [6:0] SCRATCH_SLOT = 7'h00;
   localparam logic [6:0] FIRST_CHAN = 7'h01;
   localparam logic [6:0] LAST_CHAN = 7'h64;

   // settings word: frequency, mode, auxiliary parameters
   localparam int unsigned FREQ_W = 32;
   localparam int unsigned MODE_W = 4;
   localparam int unsigned AUX_W = 16;
   localparam int unsigned SET_W = FREQ_W + MODE_W + AUX_W;

   // front-panel key bit positions inside the key bus
   localparam int unsigned K_STORE = 0;
   localparam int unsigned K_RECALL = 1;
   localparam int unsigned K_SCROLL = 2;
   localparam int unsigned K_TUNE = 3;
   localparam int unsigned K_SCRATCH = 4;
   localparam int unsigned K_CLEAR = 5;
   localparam int unsigned K_KNOB_UP = 6;
   localparam int unsigned K_KNOB_DN = 7;
   localparam int unsigned K_DIGIT = 8;
   localparam int unsigned KEY_W = 9;
   localparam int unsigned DIG_W = 4;
   localparam int unsigned IN_W = KEY_W + DIG_W;
   localparam int unsigned MAX_DIGITS = 3;

   // message times
   localparam longint unsigned CLK_HZ = 200000000;
   localparam int unsigned FULL_MSG_MS = 3000;
   localparam int unsigned RECALL_MSG_MS = 2000;
   localparam int unsigned CLR_WIN_MS = 2000;
   localparam int unsigned CLEARED_MSG_MS = 2000;
   localparam int unsigned FULL_MSG_CYC = int'(FULL_MSG_MS * (CLK_HZ / 1000));
   localparam int unsigned RECALL_MSG_CYC = int'(RECALL_MSG_MS * (CLK_HZ / 1000));
   localparam int unsigned CLR_WIN_CYC = int'(CLR_WIN_MS * (CLK_HZ / 1000));
   localparam int unsigned CLEARED_MSG_CYC = int'(CLEARED_MSG_MS * (CLK_HZ / 1000));
   localparam int unsigned TIMER_W = 30;

   typedef enum logic [3:0] {
      MSG_NONE,
      MSG_STORE_PROMPT,
      MSG_MENU,
      MSG_FULL,
      MSG_SCRATCH,
      MSG_RECALL_PROMPT,
      MSG_RECALLED,
      MSG_CONFIRM_OVW,
      MSG_CONFIRM_CLR,
      MSG_CLEARED
   } msg_t;

   typedef enum logic [3:0] {
      S_IDLE,
      S_STORE_SEL,
      S_FULL,
      S_SCRATCH,
      S_RECALL_SEL,
      S_RECALL_MSG,
      S_SCROLL,
      S_SCROLL_CONF,
      S_TUNE,
      S_TUNE_CONF,
      S_TUNE_CLR,
      S_CLEARED
   } state_t;
endpackage
`default_nettype wire

// *** rtl/channel_memory_controller.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - first Store enters store mode, shows prompt, takes keypad channel 1..100
// - occupied keypad target is overwritten silently, no confirmation
// - second Store after a number writes settings there, shows channel menu
// - clear abandons an unfinished store unwritten; also aborts recall entry and scroll mode
// - Store twice with no number writes lowest empty slot, shows it
// - no empty slot: memory-full message three seconds, then store prompt
// - Store then Scratch saves to scratchpad; notice while held, menu on release
// - Recall, number, Recall loads slot, recalled message two seconds, then menu
// - later tuning never alters a stored slot; only stores write slots
// - scroll knob steps occupied slots only, displaying without activating
// - Recall in scroll loads displayed slot and leaves scroll mode
// - Store in scroll asks confirmation; Store overwrites, two clears cancel
// - tune knob activates slots temporarily; panel controls locked meanwhile
// - Recall in tune fully activates displayed slot and leaves tune mode
// - Store in tune asks confirmation; Store overwrites, one clear cancels
// - clear in tune shows confirmation two seconds; second clear empties slot
// - cleared message two seconds, then menu advances to next-higher entry
// - no second clear in window: slot kept, menu entry restored
// - reset marks every slot empty
module channel_memory_controller #(
   parameter int unsigned FullMsgCycles = chanmem_pkg::FULL_MSG_CYC,
   parameter int unsigned RecallMsgCycles = chanmem_pkg::RECALL_MSG_CYC,
   parameter int unsigned ClrWinCycles = chanmem_pkg::CLR_WIN_CYC,
   parameter int unsigned ClearedMsgCycles = chanmem_pkg::CLEARED_MSG_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [chanmem_pkg::KEY_W-1:0] keyRaw,
   input wire logic [chanmem_pkg::DIG_W-1:0] digitRaw,
   input wire logic [chanmem_pkg::SET_W-1:0] curSettings,
   output chanmem_pkg::msg_t dispMsg,
   output logic [chanmem_pkg::CHAN_W-1:0] dispChan,
   output logic [chanmem_pkg::SET_W-1:0] dispSettings,
   output logic rxLoad,
   output logic [chanmem_pkg::SET_W-1:0] rxSettings,
   output logic monitorActive,
   output logic panelLock
);
   import chanmem_pkg::*;

   typedef struct packed {
      state_t st;
      msg_t msg;
      logic [IN_W-1:0] s1;
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      logic [IN_W-1:0] stab;
      logic [IN_W-1:0] prev;
      logic [NUM_CHAN:0] occ;
      logic [CHAN_W-1:0] chan;
      logic [9:0] ent;
      logic [1:0] entCnt;
      logic [TIMER_W-1:0] timer;
      logic clrOnce;
      logic [SET_W-1:0] dispSet;
      logic rxLoad;
      logic [SET_W-1:0] rxSet;
      logic monitor;
      logic lock;
   } ctl_t;

   ctl_t q_ff;
   ctl_t nxt_q;
   logic [SET_W-1:0] mem [0:NUM_CHAN];
   logic wrEn;
   logic [CHAN_W-1:0] wrAddr;
   logic [KEY_W-1:0] press;
   logic [DIG_W-1:0] digit;
   logic [CHAN_W-1:0] knobChan;
   logic [CHAN_W-1:0] firstOcc;
   logic [CHAN_W-1:0] lowEmpty;
   logic [CHAN_W-1:0] entChan;
   logic entValid;
   logic tmo;

   // nearest occupied slot after cur in the given direction, wrapping; 0 if none
   function automatic logic [CHAN_W-1:0] nextOcc(input logic [NUM_CHAN:0] o,
                                                 input logic [CHAN_W-1:0] cur,
                                                 input logic up);
      logic [CHAN_W-1:0] r;
      int c;
      r = '0;
      for (int i = NUM_CHAN; i >= 1; i--) begin
         c = up ? int'(cur) + i : int'(cur) - i;
         if (c > int'(NUM_CHAN)) c = c - int'(NUM_CHAN);
         if (c < 1) c = c + int'(NUM_CHAN);
         if (o[c]) r = CHAN_W'(c);
      end
      return r;
   endfunction

   function automatic logic [CHAN_W-1:0] lowestEmpty(input logic [NUM_CHAN:0] o);
      logic [CHAN_W-1:0] r;
      r = '0;
      for (int i = NUM_CHAN; i >= 1; i--) begin
         if (!o[i]) r = CHAN_W'(i);
      end
      return r;
   endfunction

   always_comb begin
      nxt_q = q_ff;
      wrEn = 1'b0;
      wrAddr = '0;
      nxt_q.rxLoad = 1'b0;
      // panel pins: three stages, a change is taken once stages two and three agree
      nxt_q.s1 = {digitRaw, keyRaw};
      nxt_q.s2 = q_ff.s1;
      nxt_q.s3 = q_ff.s2;
      nxt_q.stab = (q_ff.s2 & ~(q_ff.s2 ^ q_ff.s3)) | (q_ff.stab & (q_ff.s2 ^ q_ff.s3));
      nxt_q.prev = q_ff.stab;
      press = q_ff.stab[KEY_W-1:0] & ~q_ff.prev[KEY_W-1:0];
      digit = q_ff.stab[IN_W-1:KEY_W];
      tmo = (q_ff.timer == '0);
      if (!tmo) nxt_q.timer = q_ff.timer - TIMER_W'(1);
      // after a clear the advance always searches upward; the slot's own flag is already low
      knobChan = nextOcc(q_ff.occ, q_ff.chan, press[K_KNOB_UP] || q_ff.st == S_CLEARED);
      firstOcc = nextOcc(q_ff.occ, SCRATCH_SLOT, 1'b1);
      lowEmpty = lowestEmpty(q_ff.occ);
      entChan = q_ff.ent[CHAN_W-1:0];
      entValid = (q_ff.entCnt != 2'h0) && (q_ff.ent >= 10'(FIRST_CHAN))
                 && (q_ff.ent <= 10'(LAST_CHAN));
      // keypad digits accumulate in both selection states
      if ((q_ff.st == S_STORE_SEL || q_ff.st == S_RECALL_SEL) && press[K_DIGIT]
          && q_ff.entCnt < 2'(MAX_DIGITS)) begin
         nxt_q.ent = 10'(q_ff.ent * 10'h00a + 10'(digit));
         nxt_q.entCnt = q_ff.entCnt + 2'h1;
      end
      unique case (q_ff.st)
         S_IDLE: begin
            if (press[K_STORE]) begin
               nxt_q.st = S_STORE_SEL;
               nxt_q.msg = MSG_STORE_PROMPT;
               nxt_q.ent = '0;
               nxt_q.entCnt = '0;
            end else if (press[K_RECALL]) begin
               nxt_q.st = S_RECALL_SEL;
               nxt_q.msg = MSG_RECALL_PROMPT;
               nxt_q.ent = '0;
               nxt_q.entCnt = '0;
            end else if ((press[K_SCROLL] || press[K_TUNE]) && firstOcc != '0) begin
               // entry lands on the lowest occupied slot
               nxt_q.chan = firstOcc;
               nxt_q.msg = MSG_MENU;
               if (press[K_TUNE]) begin
                  nxt_q.st = S_TUNE;
                  nxt_q.rxLoad = 1'b1;
                  nxt_q.rxSet = mem[firstOcc];
               end else begin
                  nxt_q.st = S_SCROLL;
               end
            end
         end
         S_STORE_SEL: begin
            if (press[K_CLEAR]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_NONE;
            end else if (press[K_SCRATCH]) begin
               wrEn = 1'b1;
               wrAddr = SCRATCH_SLOT;
               nxt_q.chan = SCRATCH_SLOT;
               nxt_q.st = S_SCRATCH;
               nxt_q.msg = MSG_SCRATCH;
            end else if (press[K_STORE]) begin
               if (q_ff.entCnt == 2'h0) begin
                  if (lowEmpty != '0) begin
                     wrEn = 1'b1;
                     wrAddr = lowEmpty;
                     nxt_q.chan = lowEmpty;
                     nxt_q.st = S_IDLE;
                     nxt_q.msg = MSG_MENU;
                  end else begin
                     nxt_q.st = S_FULL;
                     nxt_q.msg = MSG_FULL;
                     nxt_q.timer = TIMER_W'(FullMsgCycles - 1);
                  end
               end else if (entValid) begin
                  // occupied or not, the slot is simply replaced
                  wrEn = 1'b1;
                  wrAddr = entChan;
                  nxt_q.chan = entChan;
                  nxt_q.st = S_IDLE;
                  nxt_q.msg = MSG_MENU;
               end else begin
                  // out-of-range number: entry restarts, prompt stays
                  nxt_q.ent = '0;
                  nxt_q.entCnt = '0;
               end
            end
         end
         S_FULL: begin
            if (press[K_CLEAR]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_NONE;
            end else if (tmo) begin
               nxt_q.st = S_STORE_SEL;
               nxt_q.msg = MSG_STORE_PROMPT;
               nxt_q.ent = '0;
               nxt_q.entCnt = '0;
            end
         end
         S_SCRATCH: begin
            if (!q_ff.stab[K_SCRATCH]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_MENU;
            end
         end
         S_RECALL_SEL: begin
            if (press[K_CLEAR]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_NONE;
            end else if (press[K_RECALL]) begin
               if (entValid && q_ff.occ[entChan]) begin
                  nxt_q.rxLoad = 1'b1;
                  nxt_q.rxSet = mem[entChan];
                  nxt_q.chan = entChan;
                  nxt_q.st = S_RECALL_MSG;
                  nxt_q.msg = MSG_RECALLED;
                  nxt_q.timer = TIMER_W'(RecallMsgCycles - 1);
               end else begin
                  // empty or out-of-range slot has nothing to load
                  nxt_q.ent = '0;
                  nxt_q.entCnt = '0;
               end
            end
         end
         S_RECALL_MSG: begin
            if (tmo) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_MENU;
            end
         end
         S_SCROLL: begin
            if (press[K_RECALL]) begin
               nxt_q.rxLoad = 1'b1;
               nxt_q.rxSet = mem[q_ff.chan];
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_MENU;
            end else if (press[K_STORE]) begin
               nxt_q.st = S_SCROLL_CONF;
               nxt_q.msg = MSG_CONFIRM_OVW;
               nxt_q.clrOnce = 1'b0;
            end else if (press[K_CLEAR] || press[K_SCROLL]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_NONE;
            end else if ((press[K_KNOB_UP] || press[K_KNOB_DN]) && knobChan != '0) begin
               nxt_q.chan = knobChan;
            end
         end
         S_SCROLL_CONF: begin
            if (press[K_STORE]) begin
               wrEn = 1'b1;
               wrAddr = q_ff.chan;
               nxt_q.st = S_SCROLL;
               nxt_q.msg = MSG_MENU;
            end else if (press[K_CLEAR]) begin
               // a single stray clear must not drop the confirmation
               nxt_q.clrOnce = 1'b1;
               if (q_ff.clrOnce) begin
                  nxt_q.st = S_SCROLL;
                  nxt_q.msg = MSG_MENU;
               end
            end
         end
         S_TUNE: begin
            if (press[K_RECALL]) begin
               nxt_q.rxLoad = 1'b1;
               nxt_q.rxSet = mem[q_ff.chan];
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_MENU;
            end else if (press[K_STORE]) begin
               nxt_q.st = S_TUNE_CONF;
               nxt_q.msg = MSG_CONFIRM_OVW;
            end else if (press[K_CLEAR]) begin
               nxt_q.st = S_TUNE_CLR;
               nxt_q.msg = MSG_CONFIRM_CLR;
               nxt_q.timer = TIMER_W'(ClrWinCycles - 1);
            end else if (press[K_TUNE]) begin
               nxt_q.st = S_IDLE;
               nxt_q.msg = MSG_NONE;
            end else if ((press[K_KNOB_UP] || press[K_KNOB_DN]) && knobChan != '0) begin
               nxt_q.chan = knobChan;
               nxt_q.rxLoad = 1'b1;
               nxt_q.rxSet = mem[knobChan];
            end
         end
         S_TUNE_CONF: begin
            if (press[K_STORE]) begin
               wrEn = 1'b1;
               wrAddr = q_ff.chan;
               nxt_q.st = S_TUNE;
               nxt_q.msg = MSG_MENU;
            end else if (press[K_CLEAR]) begin
               nxt_q.st = S_TUNE;
               nxt_q.msg = MSG_MENU;
            end
         end
         S_TUNE_CLR: begin
            if (press[K_CLEAR]) begin
               nxt_q.occ[q_ff.chan] = 1'b0;
               nxt_q.st = S_CLEARED;
               nxt_q.msg = MSG_CLEARED;
               nxt_q.timer = TIMER_W'(ClearedMsgCycles - 1);
            end else if (tmo) begin
               nxt_q.st = S_TUNE;
               nxt_q.msg = MSG_MENU;
            end
         end
         S_CLEARED: begin
            if (tmo) begin
               if (knobChan != '0) begin
                  nxt_q.chan = knobChan;
                  nxt_q.st = S_TUNE;
                  nxt_q.msg = MSG_MENU;
                  nxt_q.rxLoad = 1'b1;
                  nxt_q.rxSet = mem[knobChan];
               end else begin
                  nxt_q.st = S_IDLE;
                  nxt_q.msg = MSG_NONE;
               end
            end
         end
      endcase
      if (wrEn) nxt_q.occ[wrAddr] = 1'b1;
      nxt_q.dispSet = (wrEn && wrAddr == nxt_q.chan) ? curSettings : mem[nxt_q.chan];
      // tune states lock the panel and keep the temporary load
      nxt_q.monitor = (nxt_q.st inside {S_TUNE, S_TUNE_CONF, S_TUNE_CLR, S_CLEARED});
      nxt_q.lock = nxt_q.monitor;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // slot contents need no reset; the occupied flags decide what is valid
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= curSettings;
      end
   end

   assign dispMsg = q_ff.msg;
   assign dispChan = q_ff.chan;
   assign dispSettings = q_ff.dispSet;
   assign rxLoad = q_ff.rxLoad;
   assign rxSettings = q_ff.rxSet;
   assign monitorActive = q_ff.monitor;
   assign panelLock = q_ff.lock;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   storePrompt_a: assert property (
      q_ff.st == S_IDLE && press[K_STORE] |=> dispMsg == MSG_STORE_PROMPT)
      else $error("store press did not raise the store prompt");
   abortNoWrite_a: assert property (
      q_ff.st == S_STORE_SEL && press[K_CLEAR] |-> !wrEn ##1 q_ff.st == S_IDLE)
      else $error("clear during store wrote a slot or did not abort");
   keypadStore_a: assert property (
      q_ff.st == S_STORE_SEL && press[K_STORE] && entValid
      |-> wrEn && wrAddr == entChan ##1 dispMsg == MSG_MENU && dispChan == $past(entChan))
      else $error("keypad store missed its slot or menu display");
   autoStore_a: assert property (
      q_ff.st == S_STORE_SEL && press[K_STORE] && q_ff.entCnt == 2'h0 && lowEmpty != '0
      |-> wrEn && wrAddr == lowEmpty)
      else $error("double store did not pick the lowest empty slot");
   fullMsg_a: assert property (
      q_ff.st == S_FULL && tmo && !press[K_CLEAR] |=> dispMsg == MSG_STORE_PROMPT)
      else $error("memory full message did not return to prompt");
   occSet_a: assert property (
      wrEn |=> q_ff.occ[$past(wrAddr)])
      else $error("stored slot not flagged occupied");
   onlyStoresWrite_a: assert property (
      wrEn |-> press[K_STORE] || press[K_SCRATCH])
      else $error("slot written without a store");
   recallLoad_a: assert property (
      q_ff.st == S_RECALL_SEL && press[K_RECALL] && entValid && q_ff.occ[entChan]
      |=> rxLoad && !monitorActive && dispMsg == MSG_RECALLED
          ##1 !rxLoad && dispMsg == MSG_RECALLED)
      else $error("recall did not load slot and show recalled message");
   scrollQuiet_a: assert property (
      q_ff.st == S_SCROLL |-> q_ff.occ[dispChan] && !rxLoad && !monitorActive)
      else $error("scroll showed an empty slot or activated it");
   tuneLock_a: assert property (
      q_ff.st == S_TUNE |-> panelLock && monitorActive)
      else $error("tune mode without panel lock");
   clearSlot_a: assert property (
      q_ff.st == S_TUNE_CLR && press[K_CLEAR]
      |=> q_ff.st == S_CLEARED && !q_ff.occ[$past(q_ff.chan)])
      else $error("second clear did not empty the slot");
   clearTimeout_a: assert property (
      q_ff.st == S_TUNE_CLR && tmo && !press[K_CLEAR]
      |=> q_ff.st == S_TUNE && q_ff.occ[dispChan])
      else $error("clear window expiry did not keep the slot");

   autoStore_c: cover property (q_ff.st == S_STORE_SEL && wrEn && q_ff.entCnt == 2'h0);
   full_c: cover property (q_ff.st == S_FULL ##1 q_ff.st == S_STORE_SEL);
   recall_c: cover property (q_ff.st == S_RECALL_MSG ##1 q_ff.st == S_IDLE);
   clearAdvance_c: cover property (q_ff.st == S_CLEARED ##1 q_ff.st == S_TUNE);
endmodule
`default_nettype wire

// *** dv/panel_operator.sv ***
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
   input wire logic clk_sys,
   output var logic [chanmem_pkg::KEY_W-1:0] keyRaw,
   output var logic [chanmem_pkg::DIG_W-1:0] digitRaw
);
   import chanmem_pkg::*;
   initial begin
      keyRaw = '0;
      digitRaw = '0;
   end
   // 8 cycles per level: sync needs 4, presses must be 8 apart
   task automatic hold(input int k, input logic v);
      @(negedge clk_sys);
      keyRaw[k] = v;
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic press(input int k);
      hold(k, 1'b1);
      hold(k, 1'b0);
   endtask
   // digit level settles a cycle before its strobe rises
   task automatic digit(input int d);
      digitRaw = 4'(d);
      press(K_DIGIT);
   endtask
   task automatic chan(input int n);
      if (n >= 100) digit(n / 100);
      if (n >= 10) digit((n / 10) % 10);
      digit(n % 10);
   endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import chanmem_pkg::*;
   // short message times keep the run brief
   localparam int unsigned T = 40;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [KEY_W-1:0] keyRaw;
   logic [DIG_W-1:0] digitRaw;
   logic [SET_W-1:0] cur, dispSettings, rxSettings;
   logic [CHAN_W-1:0] dispChan;
   msg_t dispMsg;
   logic rxLoad, monitorActive, panelLock;
   logic [SET_W-1:0] mem [0:100];
   bit occ [0:100];
   int bad_count = 0;
   int checked = 0;
   int loads = 0;
   int cycles = 0;
   int l;

   initial forever #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (rxLoad === 1'b1) loads <= loads + 1;
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end

   channel_memory_controller #(.FullMsgCycles(T), .RecallMsgCycles(T), .ClrWinCycles(T),
      .ClearedMsgCycles(T)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .keyRaw(keyRaw),
      .digitRaw(digitRaw), .curSettings(cur), .dispMsg(dispMsg), .dispChan(dispChan),
      .dispSettings(dispSettings), .rxLoad(rxLoad), .rxSettings(rxSettings),
      .monitorActive(monitorActive), .panelLock(panelLock));
   panel_operator op_u (.clk_sys(clk_sys), .keyRaw(keyRaw), .digitRaw(digitRaw));

   task automatic chk(input logic [SET_W-1:0] got, input logic [SET_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_msg(input msg_t exp);
      checked++;
      if (dispMsg !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t message %0d expected %0d", $time, dispMsg, exp);
      end
   endtask
   task automatic chk_view(input msg_t m, input int c);
      chk_msg(m);
      chk(SET_W'(dispChan), SET_W'(c));
   endtask
   function automatic int lowest();
      for (int i = 1; i <= 100; i++) if (!occ[i]) return i;
      return 0;
   endfunction
   task automatic new_cur();
      @(negedge clk_sys);
      cur = {$urandom(), 20'($urandom())};
   endtask
   task automatic key_store(input int n);
      new_cur();
      op_u.press(K_STORE);
      chk_msg(MSG_STORE_PROMPT);
      op_u.chan(n);
      op_u.press(K_STORE);
      chk_view(MSG_MENU, n);
      chk(dispSettings, cur);
      mem[n] = cur;
      occ[n] = 1'b1;
   endtask
   task automatic auto_store();
      new_cur();
      op_u.press(K_STORE);
      op_u.press(K_STORE);
      chk_view(MSG_MENU, lowest());
      chk(dispSettings, cur);
      mem[lowest()] = cur;
      occ[lowest()] = 1'b1;
   endtask
   task automatic recall(input int n);
      l = loads;
      op_u.press(K_RECALL);
      op_u.chan(n);
      op_u.press(K_RECALL);
      chk(SET_W'(loads), SET_W'(l + 1));
      chk(rxSettings, mem[n]);
      chk_view(MSG_RECALLED, n);
   endtask
   task automatic finish_test();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      cur = '0;
      void'($urandom(32'h84c40726));
      repeat (2) @(negedge clk_sys);
      chk_view(MSG_NONE, 0);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      auto_store();
      key_store(25);
      key_store(25);
      new_cur();
      op_u.press(K_STORE);
      op_u.chan(7);
      op_u.press(K_CLEAR);
      chk_msg(MSG_NONE);
      auto_store();
      recall(25);
      new_cur();
      repeat (T + 10) @(negedge clk_sys);
      chk_view(MSG_MENU, 25);
      recall(25);
      // recalled message ignores keys until it times out
      repeat (T + 10) @(negedge clk_sys);
      l = loads;
      op_u.press(K_SCROLL);
      chk_view(MSG_MENU, 1);
      op_u.press(K_KNOB_UP);
      chk_view(MSG_MENU, 2);
      op_u.press(K_KNOB_UP);
      chk_view(MSG_MENU, 25);
      chk(SET_W'(loads), SET_W'(l));
      chk(SET_W'(monitorActive), '0);
      op_u.press(K_STORE);
      chk_msg(MSG_CONFIRM_OVW);
      op_u.press(K_CLEAR);
      op_u.press(K_CLEAR);
      chk_view(MSG_MENU, 25);
      new_cur();
      op_u.press(K_STORE);
      op_u.press(K_STORE);
      chk(dispSettings, cur);
      mem[25] = cur;
      op_u.press(K_RECALL);
      chk(SET_W'(loads), SET_W'(l + 1));
      chk(rxSettings, mem[25]);
      op_u.press(K_KNOB_UP);
      chk(SET_W'(dispChan), SET_W'(25));
      op_u.press(K_TUNE);
      chk(SET_W'({monitorActive, panelLock}), SET_W'(3));
      chk_view(MSG_MENU, 1);
      chk(rxSettings, mem[1]);
      op_u.press(K_KNOB_UP);
      chk(rxSettings, mem[2]);
      op_u.press(K_STORE);
      chk_msg(MSG_CONFIRM_OVW);
      op_u.press(K_CLEAR);
      chk_view(MSG_MENU, 2);
      new_cur();
      op_u.press(K_STORE);
      op_u.press(K_STORE);
      chk_view(MSG_MENU, 2);
      chk(dispSettings, cur);
      mem[2] = cur;
      op_u.press(K_CLEAR);
      chk_msg(MSG_CONFIRM_CLR);
      repeat (T + 10) @(negedge clk_sys);
      chk_view(MSG_MENU, 2);
      op_u.press(K_CLEAR);
      op_u.press(K_CLEAR);
      chk_view(MSG_CLEARED, 2);
      occ[2] = 1'b0;
      repeat (T + 10) @(negedge clk_sys);
      chk_view(MSG_MENU, 25);
      chk(rxSettings, mem[25]);
      l = loads;
      op_u.press(K_RECALL);
      chk(SET_W'(monitorActive), '0);
      chk(SET_W'(loads), SET_W'(l + 1));
      chk(rxSettings, mem[25]);
      new_cur();
      op_u.press(K_STORE);
      op_u.hold(K_SCRATCH, 1'b1);
      chk_view(MSG_SCRATCH, 0);
      chk(dispSettings, cur);
      op_u.hold(K_SCRATCH, 1'b0);
      chk_msg(MSG_MENU);
      // lowest empty must refill slot 2, then all the rest
      while (lowest() != 0) auto_store();
      op_u.press(K_STORE);
      op_u.press(K_STORE);
      chk_msg(MSG_FULL);
      repeat (T + 10) @(negedge clk_sys);
      chk_msg(MSG_STORE_PROMPT);
      // mid-run reset must empty every slot
      arst_n = 1'b0;
      @(negedge clk_sys);
      arst_n = 1'b1;
      foreach (occ[i]) occ[i] = 1'b0;
      repeat (4) @(negedge clk_sys);
      op_u.press(K_SCROLL);
      chk_view(MSG_NONE, 0);
      auto_store();
      finish_test();
   end
endmodule
`default_nettype wire
